// ### design/arlc_top.sv
// Restart request and command-list swap control with its register file.
// Assumes the conversion engine and internal interface run on mclk.
//
// Notes on behaviour
// - Restart request flag at bit 5 restarts fetching from top of list.
// - Restart request clears once the first top command is loaded.
// - Both flags settable only while enabled, cleared while disabled.
// - Writing zero to either flag from the bus changes nothing.
// - Bus restart while already requested keeps flag and flags overrun.
// - Internal restart sets the request; a repeat while set overruns.
// - Trigger mode restart sets trigger request if engine idle and list done or aborted.
// - Swap ready at bit 4 means swap at restart; clears when swap done.
// - Swap ready is held at zero without double buffer mode.
// - Writing one does not clear a set swap ready flag.
// - Internal restart samples swap ready input to set the swap flag.
// - Restart mode restart without swap ready raises missing swap error.
// - No missing swap error on first restart after enable, stop, reset.
// - Swap ready reads zero when loaded, one when still to load.
// - Trigger mode restart with trigger together is a collision and halts.
// - Restart sets sequence abort while busy or before list completion.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module arlc_top
	import arlc_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          nrst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire arlc_int_req_t int_req,
	input  wire arlc_eng_t     eng,
	output arlc_flags_t        flags,
	output logic               swap_lists,
	output logic               converter_halted,
	output logic               irq
);

	logic          wr_en, wr_lane0, wr_hit, rd_en, rd_hit;
	logic [AW-1:0] wr_addr, rd_addr;
	logic [31:0]   wr_data, rd_data;

	arlc_axil u_axil (
		.mclk          (mclk),
		.nrst          (nrst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_lane0      (wr_lane0),
		.wr_hit        (wr_hit),
		.rd_en         (rd_en),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_hit        (rd_hit)
	);

	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [IRQ_W-1:0]  stat_q, stat_d, mask_q, mask_d;
	logic restart_request_flag_q, restart_request_flag_d, list_swap_ready_q, list_swap_ready_d, trigger_request_flag_q, trigger_request_flag_d, sequence_abort_flag_q, sequence_abort_flag_d;
	logic halt_q, halt_d, first_q, first_d, enp_q, enp_d;
	logic swap_q, swap_d, irq_q, irq_d;

	logic      en, dbm, trgm, bus_ctl, int_ctl, active, soft_rst;
	logic      wr_ctrl, wr_flow, wr_mask, rd_stat;
	logic      bus_rst, bus_ld, int_rst, int_ld, rst_req, ld_req;
	logic      abort_req, trg_req, collision, new_rst, ovr, cmd_clear;
	logic      first_eff, list_done, missing;
	arlc_acc_t acc;

	always_comb begin
		acc      = arlc_acc_t'(ctrl_q[CTRL_ACC +: 2]);
		en       = ctrl_q[CTRL_EN];
		dbm      = ctrl_q[CTRL_DBM];
		trgm     = ctrl_q[CTRL_TRGM];
		bus_ctl  = (acc == ACC_BUS) || (acc == ACC_BOTH);
		int_ctl  = (acc == ACC_INT) || (acc == ACC_BOTH);
		wr_ctrl  = wr_en && wr_lane0 && (wr_addr == OFS_CTRL);
		wr_flow  = wr_en && wr_lane0 && (wr_addr == OFS_FLOW);
		wr_mask  = wr_en && wr_lane0 && (wr_addr == OFS_MASK);
		rd_stat  = rd_en && (rd_addr == OFS_STAT);
		soft_rst = wr_ctrl && wr_data[CTRL_SRST];
		active   = en && !halt_q && !soft_rst;
		bus_rst  = bus_ctl && wr_flow && wr_data[FLOW_RESTART_REQUEST_FLAG];
		bus_ld   = bus_rst && wr_data[FLOW_LIST_SWAP_READY];
		int_rst  = int_ctl && int_req.restart;
		int_ld   = int_rst && int_req.swap_ready;
		rst_req  = bus_rst || int_rst;
		ld_req   = (bus_ld || int_ld) && dbm;
		abort_req = (bus_ctl && wr_flow && wr_data[FLOW_SEQUENCE_ABORT_FLAG])
			|| (int_ctl && int_req.abort);
		trg_req  = (bus_ctl && wr_flow && wr_data[FLOW_TRIGGER_REQUEST_FLAG])
			|| (int_ctl && int_req.trigger);
		collision = active && trgm && rst_req && trg_req;
		new_rst  = active && rst_req && !restart_request_flag_q && !collision;
		// bus or internal repeat overruns
		// Two sources in one cycle are one restart plus one overrun.
		ovr      = active && ((rst_req && restart_request_flag_q) || (bus_rst && int_rst));
		cmd_clear = restart_request_flag_q && eng.cmd_loaded;
		first_eff = first_q || (en && !enp_q) || eng.stop_exit;
		list_done = eng.eol_reached || sequence_abort_flag_q || abort_req;
		missing  = new_rst && !trgm && !list_swap_ready_q && !ld_req && !first_eff
			&& !sequence_abort_flag_q && !abort_req;
	end

	always_comb begin
		ctrl_d  = ctrl_q;
		mask_d  = mask_q;
		restart_request_flag_d  = restart_request_flag_q;
		list_swap_ready_d  = list_swap_ready_q;
		trigger_request_flag_d  = trigger_request_flag_q;
		sequence_abort_flag_d  = sequence_abort_flag_q;
		halt_d  = halt_q;
		enp_d   = en;
		swap_d  = 1'b0;
		first_d = soft_rst || (first_eff && !new_rst);
		if (wr_ctrl) begin
			ctrl_d = wr_data[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_SRST);
		end
		if (wr_mask) begin
			mask_d = wr_data[IRQ_W-1:0];
		end
		if (cmd_clear) begin
			restart_request_flag_d = 1'b0;
			list_swap_ready_d = 1'b0;
			swap_d = list_swap_ready_q;
		end
		if (new_rst) begin
			restart_request_flag_d = 1'b1;
			if (ld_req) begin
				list_swap_ready_d = 1'b1;
			end
		end
		if (eng.trigger_request_flag_taken) begin
			trigger_request_flag_d = 1'b0;
		end
		if (new_rst && trgm && !eng.busy && list_done) begin
			trigger_request_flag_d = 1'b1;
		end
		if (active && trg_req && !collision) begin
			trigger_request_flag_d = 1'b1;
		end
		if (eng.abort_done) begin
			sequence_abort_flag_d = 1'b0;
		end
		if (new_rst && ((eng.busy && !sequence_abort_flag_q && !abort_req)
			|| (!eng.busy && !list_done))) begin
			sequence_abort_flag_d = 1'b1;
		end
		if (active && abort_req) begin
			sequence_abort_flag_d = 1'b1;
		end
		if (collision) begin
			halt_d = 1'b1;
		end
		if (!en || soft_rst) begin
			restart_request_flag_d = 1'b0;
			list_swap_ready_d = 1'b0;
			trigger_request_flag_d = 1'b0;
			sequence_abort_flag_d = 1'b0;
			halt_d = 1'b0;
		end
		if (!dbm) begin
			list_swap_ready_d = 1'b0;
		end
		// sticky overrun
		// A read clears the status, but an event in the same cycle survives it.
		stat_d = rd_stat ? '0 : stat_q;
		stat_d[IRQ_OVR]  = stat_d[IRQ_OVR] || ovr;
		stat_d[IRQ_MSW]  = stat_d[IRQ_MSW] || missing;
		stat_d[IRQ_TCOL] = stat_d[IRQ_TCOL] || collision;
		irq_d = |(stat_d & mask_d);
	end

	always_comb begin
		rd_data = 32'h0;
		rd_hit  = 1'b1;
		case (rd_addr)
			OFS_CTRL: rd_data[CTRL_W-1:0] = ctrl_q;
			OFS_FLOW: begin
				rd_data[FLOW_LIST_SWAP_READY] = list_swap_ready_q;
				rd_data[FLOW_RESTART_REQUEST_FLAG] = restart_request_flag_q;
				rd_data[FLOW_TRIGGER_REQUEST_FLAG] = trigger_request_flag_q;
				rd_data[FLOW_SEQUENCE_ABORT_FLAG] = sequence_abort_flag_q;
			end
			OFS_STAT: rd_data[IRQ_W-1:0] = stat_q;
			OFS_MASK: rd_data[IRQ_W-1:0] = mask_q;
			default:  rd_hit = 1'b0;
		endcase
		wr_hit = (wr_addr == OFS_CTRL) || (wr_addr == OFS_FLOW)
			|| (wr_addr == OFS_STAT) || (wr_addr == OFS_MASK);
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q  <= CTRL_RST;
			mask_q  <= MASK_RST;
			stat_q  <= '0;
			restart_request_flag_q  <= 1'b0;
			list_swap_ready_q  <= 1'b0;
			trigger_request_flag_q  <= 1'b0;
			sequence_abort_flag_q  <= 1'b0;
			halt_q  <= 1'b0;
			first_q <= 1'b1;
			enp_q   <= 1'b0;
			swap_q  <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			mask_q  <= mask_d;
			stat_q  <= stat_d;
			restart_request_flag_q  <= restart_request_flag_d;
			list_swap_ready_q  <= list_swap_ready_d;
			trigger_request_flag_q  <= trigger_request_flag_d;
			sequence_abort_flag_q  <= sequence_abort_flag_d;
			halt_q  <= halt_d;
			first_q <= first_d;
			enp_q   <= enp_d;
			swap_q  <= swap_d;
			irq_q   <= irq_d;
		end
	end

	assign flags.restart_request_flag = restart_request_flag_q;
	assign flags.list_swap_ready      = list_swap_ready_q;
	assign flags.trigger_request_flag = trigger_request_flag_q;
	assign flags.sequence_abort_flag  = sequence_abort_flag_q;
	assign swap_lists       = swap_q;
	assign converter_halted = halt_q;
	assign irq              = irq_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_swap_load;
		restart_request_flag_q && list_swap_ready_q && eng.cmd_loaded && !rst_req && en && dbm;
	endsequence
	AST_DISABLE_CLEARS: assert property (
		!en |=> !restart_request_flag_q && !list_swap_ready_q)
		else $error("flags survive disable");
	AST_FIRST_LOAD_CLEARS: assert property (
		restart_request_flag_q && eng.cmd_loaded && !rst_req |=> !restart_request_flag_q)
		else $error("restart request not cleared on load");
	AST_ZERO_WRITE_KEEPS: assert property (
		restart_request_flag_q && wr_flow && !wr_data[FLOW_RESTART_REQUEST_FLAG] && en && !soft_rst
		&& !eng.cmd_loaded |=> restart_request_flag_q)
		else $error("zero write cleared restart request");
	AST_BUS_OVERRUN: assert property (
		active && bus_rst && restart_request_flag_q |=> restart_request_flag_q && stat_q[IRQ_OVR])
		else $error("bus overrun not flagged");
	AST_INT_SET: assert property (
		active && int_rst && !restart_request_flag_q && !collision |=> restart_request_flag_q)
		else $error("internal restart not taken");
	AST_TRIGGER_REQUEST_FLAG_SET: assert property (
		new_rst && trgm && !eng.busy && eng.eol_reached |=> trigger_request_flag_q)
		else $error("trigger request missing");
	AST_SWAP_DONE: assert property (
		s_swap_load |=> !list_swap_ready_q && swap_lists ##1 !swap_lists)
		else $error("swap not completed");
	AST_NO_DBM: assert property (
		!dbm |=> !list_swap_ready_q)
		else $error("swap ready without double buffer");
	AST_LIST_SWAP_READY_ALONE: assert property (
		!list_swap_ready_q && !int_rst && wr_flow && !wr_data[FLOW_RESTART_REQUEST_FLAG] |=> !list_swap_ready_q)
		else $error("swap ready set without restart");
	AST_ONE_KEEPS: assert property (
		list_swap_ready_q && dbm && en && !soft_rst && !cmd_clear && wr_flow |=> list_swap_ready_q)
		else $error("swap ready cleared by write");
	AST_INT_SAMPLE: assert property (
		!list_swap_ready_q && int_rst && !int_req.swap_ready && !bus_ld |=> !list_swap_ready_q)
		else $error("swap ready set with input low");
	AST_MISSING_SWAP: assert property (
		new_rst && !trgm && !list_swap_ready_q && !ld_req && !first_eff && !sequence_abort_flag_q
		&& !abort_req |=> stat_q[IRQ_MSW])
		else $error("missing swap error not raised");
	AST_FIRST_EXEMPT: assert property (
		new_rst && first_eff && !stat_q[IRQ_MSW] |=> !stat_q[IRQ_MSW])
		else $error("missing swap on first restart");
	AST_COLLISION: assert property (
		collision |=> halt_q && stat_q[IRQ_TCOL])
		else $error("collision not handled");
	AST_COLLISION_NO_SET: assert property (
		collision && !restart_request_flag_q |=> !restart_request_flag_q)
		else $error("collision started a restart");
	AST_ABORT_BUSY: assert property (
		new_rst && eng.busy && !sequence_abort_flag_q && !abort_req |=> sequence_abort_flag_q)
		else $error("abort not set on busy restart");
	AST_OVR_STICKY: assert property (
		stat_q[IRQ_OVR] && !rd_stat |=> stat_q[IRQ_OVR])
		else $error("overrun status lost");

endmodule
`default_nettype wire

// ### design/arlc_pkg.sv
// Constants, types and register map of the restart and list-swap control block.
// Assumes a single clock domain and an AXI4-Lite master on the same clock.
`default_nettype none
package arlc_pkg;

	localparam int AW = 4;

	// Register byte offsets.
	localparam logic [AW-1:0] OFS_CTRL = 4'h0;
	localparam logic [AW-1:0] OFS_FLOW = 4'h4;
	localparam logic [AW-1:0] OFS_STAT = 4'h8;
	localparam logic [AW-1:0] OFS_MASK = 4'hc;

	// Control register fields.
	localparam int CTRL_EN   = 0;
	localparam int CTRL_DBM  = 1;
	localparam int CTRL_TRGM = 2;
	localparam int CTRL_SRST = 3;
	localparam int CTRL_ACC  = 4;
	localparam int CTRL_W    = 6;

	// Flow register fields.
	localparam int FLOW_LIST_SWAP_READY = 4;
	localparam int FLOW_RESTART_REQUEST_FLAG = 5;
	localparam int FLOW_TRIGGER_REQUEST_FLAG = 6;
	localparam int FLOW_SEQUENCE_ABORT_FLAG = 7;

	// Interrupt status and mask fields.
	localparam int IRQ_OVR  = 0;
	localparam int IRQ_MSW  = 1;
	localparam int IRQ_TCOL = 2;
	localparam int IRQ_W    = 3;

	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
	localparam logic [IRQ_W-1:0]  MASK_RST = 3'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ACC_NONE = 2'h0,
		ACC_BUS  = 2'h1,
		ACC_INT  = 2'h2,
		ACC_BOTH = 2'h3
	} arlc_acc_t;

	typedef enum logic {
		WS_IDLE = 1'b0,
		WS_RESP = 1'b1
	} arlc_wst_t;

	typedef enum logic {
		RS_IDLE = 1'b0,
		RS_DATA = 1'b1
	} arlc_rst_t;

	// On-chip internal interface requests, one-cycle pulses except swap_ready.
	typedef struct packed {
		logic restart;
		logic swap_ready;
		logic trigger;
		logic abort;
	} arlc_int_req_t;

	// Status from the conversion engine.
	typedef struct packed {
		logic busy;
		logic eol_reached;
		logic cmd_loaded;
		logic abort_done;
		logic trigger_request_flag_taken;
		logic stop_exit;
	} arlc_eng_t;

	typedef struct packed {
		logic restart_request_flag;
		logic list_swap_ready;
		logic trigger_request_flag;
		logic sequence_abort_flag;
	} arlc_flags_t;

endpackage
`default_nettype wire

// ### design/arlc_axil.sv
// AXI4-Lite slave front end: turns bus transfers into write and read strobes.
// Assumes the register file answers rd_data, rd_hit and wr_hit combinationally.
`default_nettype none
module arlc_axil
	import arlc_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          nrst,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               wr_en,
	output logic [AW-1:0]      wr_addr,
	output logic [31:0]        wr_data,
	output logic               wr_lane0,
	input  wire logic          wr_hit,
	output logic               rd_en,
	output logic [AW-1:0]      rd_addr,
	input  wire logic [31:0]   rd_data,
	input  wire logic          rd_hit
);

	arlc_wst_t     wst_q, wst_d;
	arlc_rst_t     rst_q, rst_d;
	logic          awh_q, awh_d, wh_q, wh_d;
	logic [AW-1:0] awa_q, awa_d;
	logic [31:0]   wd_q, wd_d, rd_q, rd_d;
	logic [3:0]    ws_q, ws_d;
	logic [1:0]    br_q, br_d, rr_q, rr_d;

	assign s_axi_awready = (wst_q == WS_IDLE) && !awh_q;
	assign s_axi_wready  = (wst_q == WS_IDLE) && !wh_q;
	assign s_axi_bvalid  = (wst_q == WS_RESP);
	assign s_axi_bresp   = br_q;
	assign s_axi_arready = (rst_q == RS_IDLE);
	assign s_axi_rvalid  = (rst_q == RS_DATA);
	assign s_axi_rdata   = rd_q;
	assign s_axi_rresp   = rr_q;
	assign wr_en    = (wst_q == WS_IDLE) && awh_q && wh_q;
	assign wr_addr  = awa_q;
	assign wr_data  = wd_q;
	assign wr_lane0 = ws_q[0];
	assign rd_en    = s_axi_arvalid && s_axi_arready;
	assign rd_addr  = s_axi_araddr;

	always_comb begin
		wst_d = wst_q;
		rst_d = rst_q;
		awh_d = awh_q;
		wh_d  = wh_q;
		awa_d = awa_q;
		wd_d  = wd_q;
		ws_d  = ws_q;
		br_d  = br_q;
		rd_d  = rd_q;
		rr_d  = rr_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awh_d = 1'b1;
			awa_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wh_d = 1'b1;
			wd_d = s_axi_wdata;
			ws_d = s_axi_wstrb;
		end
		case (wst_q)
			WS_IDLE: if (wr_en) begin
				wst_d = WS_RESP;
				br_d  = wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			WS_RESP: if (s_axi_bready) begin
				wst_d = WS_IDLE;
				awh_d = 1'b0;
				wh_d  = 1'b0;
			end
			default: wst_d = WS_IDLE;
		endcase
		case (rst_q)
			RS_IDLE: if (rd_en) begin
				rst_d = RS_DATA;
				rd_d  = rd_data;
				rr_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			RS_DATA: if (s_axi_rready) begin
				rst_d = RS_IDLE;
			end
			default: rst_d = RS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wst_q <= WS_IDLE;
			rst_q <= RS_IDLE;
			awh_q <= 1'b0;
			wh_q  <= 1'b0;
			awa_q <= '0;
			wd_q  <= 32'h0;
			ws_q  <= 4'h0;
			br_q  <= RESP_OKAY;
			rd_q  <= 32'h0;
			rr_q  <= RESP_OKAY;
		end else begin
			wst_q <= wst_d;
			rst_q <= rst_d;
			awh_q <= awh_d;
			wh_q  <= wh_d;
			awa_q <= awa_d;
			wd_q  <= wd_d;
			ws_q  <= ws_d;
			br_q  <= br_d;
			rd_q  <= rd_d;
			rr_q  <= rr_d;
		end
	end

endmodule
`default_nettype wire

// ### bench/arlc_far.sv
// Far-side model: conversion engine status and the internal request interface.
// Assumes the bench calls its tasks one at a time from a single process.
`default_nettype none
module arlc_far
	import arlc_pkg::*;
(
	input  wire logic    mclk,
	output arlc_int_req_t int_req,
	output arlc_eng_t    eng
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		int_req = '0;
		eng = '0;
	end

	task automatic req(input arlc_int_req_t r);
		@(posedge mclk);
		int_req <= r;
		@(posedge mclk);
		// The swap level flips once the restart is gone, so late sampling shows up.
		int_req <= {1'b0, ~r.swap_ready, 2'b00};
	endtask

	// Engine pulses, in order: command loaded, abort done, trigger taken, stop exit.
	task automatic pulse(input int n, input logic [3:0] p);
		repeat (n) @(posedge mclk);
		{eng.cmd_loaded, eng.abort_done, eng.trigger_request_flag_taken, eng.stop_exit} <= p;
		@(posedge mclk);
		{eng.cmd_loaded, eng.abort_done, eng.trigger_request_flag_taken, eng.stop_exit} <= 4'h0;
	endtask

	task automatic lvl(input logic b, input logic e);
		@(posedge mclk);
		eng.busy <= b;
		eng.eol_reached <= e;
	endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the restart and list-swap control block.
// Assumes arlc_far stands in for the engine and the internal interface.
`default_nettype none
module tb
	import arlc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          mclk, nrst;
	logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]   s_axi_wdata, s_axi_rdata;
	logic [3:0]    s_axi_wstrb;
	logic [1:0]    s_axi_bresp, s_axi_rresp;
	logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic          s_axi_rvalid, s_axi_rready, swap_lists, converter_halted, irq;
	arlc_int_req_t int_req;
	arlc_eng_t     eng;
	arlc_flags_t   flags;
	int            errors = 0;
	int            tests_run = 0;
	int            nswap = 0;

	arlc_top arlc_top_i (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .int_req, .eng,
		.flags, .swap_lists, .converter_halted, .irq);
	arlc_far arlc_far_i (.mclk, .int_req, .eng);

	always @(posedge mclk) if (swap_lists === 1'b1) nswap++;

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hang();
		errors++;
		$display("wrong value at %0t: no bus answer", $time);
		stop_test();
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hf);
		logic done;
		done = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				chk(32'(s_axi_bresp), 32'(er));
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) hang();
	endtask

	task automatic rd(input logic [AW-1:0] a, input logic [31:0] e,
		input logic [1:0] er = RESP_OKAY);
		logic done;
		done = 1'b0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				chk(s_axi_rdata, e);
				chk(32'(s_axi_rresp), 32'(er));
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) hang();
	endtask

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		nrst = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hf;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_FLOW, 32'h0);
		rd(OFS_MASK, 32'h0);
		rd(4'h2, 32'h0, RESP_SLVERR);
		wr(4'h2, 32'h3f, RESP_SLVERR);
		rd(OFS_CTRL, 32'h0);
		// Only byte lane 0 carries register bits, so a cleared lane 0 writes nothing.
		wr(OFS_MASK, 32'h7, RESP_OKAY, 4'he);
		rd(OFS_MASK, 32'h0);
		$display("test reset and bus done");
		arlc_far_i.lvl(1'b0, 1'b1);
		wr(OFS_CTRL, 32'h12);
		wr(OFS_FLOW, 32'h30);
		rd(OFS_FLOW, 32'h0);
		wr(OFS_CTRL, 32'h13);
		wr(OFS_FLOW, 32'h0);
		wr(OFS_FLOW, 32'h10);
		rd(OFS_FLOW, 32'h0);
		wr(OFS_FLOW, 32'h20);
		rd(OFS_STAT, 32'h0);
		wr(OFS_FLOW, 32'h20);
		rd(OFS_FLOW, 32'h20);
		rd(OFS_STAT, 32'h1);
		rd(OFS_STAT, 32'h0);
		arlc_far_i.pulse(1, 4'h8);
		rd(OFS_FLOW, 32'h0);
		wr(OFS_FLOW, 32'h30);
		chk({28'h0, flags}, 32'hc);
		wr(OFS_FLOW, 32'h10);
		rd(OFS_FLOW, 32'h30);
		arlc_far_i.pulse(8, 4'h8);
		rd(OFS_FLOW, 32'h0);
		chk(nswap, 32'h1);
		wr(OFS_FLOW, 32'h20);
		rd(OFS_STAT, 32'h2);
		arlc_far_i.pulse(1, 4'h8);
		wr(OFS_FLOW, 32'ha0);
		rd(OFS_FLOW, 32'ha0);
		rd(OFS_STAT, 32'h0);
		arlc_far_i.pulse(2, 4'hc);
		wr(OFS_CTRL, 32'h1b);
		rd(OFS_CTRL, 32'h13);
		wr(OFS_FLOW, 32'h20);
		rd(OFS_STAT, 32'h0);
		arlc_far_i.pulse(1, 4'h8);
		arlc_far_i.pulse(1, 4'h1);
		wr(OFS_FLOW, 32'h20);
		rd(OFS_STAT, 32'h0);
		wr(OFS_CTRL, 32'h10);
		rd(OFS_FLOW, 32'h0);
		$display("test bus control done");
		wr(OFS_MASK, 32'h5);
		wr(OFS_CTRL, 32'h23);
		wr(OFS_FLOW, 32'h20);
		rd(OFS_FLOW, 32'h0);
		arlc_far_i.req(4'b1100);
		arlc_far_i.req(4'b1000);
		rd(OFS_FLOW, 32'h30);
		chk(32'(irq), 32'h1);
		rd(OFS_STAT, 32'h1);
		repeat (2) @(posedge mclk);
		chk(32'(irq), 32'h0);
		arlc_far_i.pulse(3, 4'h8);
		arlc_far_i.req(4'b1000);
		rd(OFS_FLOW, 32'h20);
		chk(32'(irq), 32'h0);
		rd(OFS_STAT, 32'h2);
		arlc_far_i.pulse(1, 4'h8);
		rd(OFS_FLOW, 32'h0);
		arlc_far_i.req(4'b1001);
		rd(OFS_FLOW, 32'ha0);
		rd(OFS_STAT, 32'h0);
		arlc_far_i.pulse(2, 4'hc);
		chk(nswap, 32'h2);
		$display("test internal control done");
		wr(OFS_CTRL, 32'h25);
		arlc_far_i.req(4'b1100);
		rd(OFS_FLOW, 32'h60);
		arlc_far_i.pulse(1, 4'ha);
		wr(OFS_CTRL, 32'h27);
		arlc_far_i.lvl(1'b1, 1'b0);
		arlc_far_i.req(4'b1100);
		rd(OFS_FLOW, 32'hb0);
		arlc_far_i.pulse(2, 4'hc);
		arlc_far_i.lvl(1'b0, 1'b1);
		arlc_far_i.req(4'b1010);
		repeat (2) @(posedge mclk);
		chk(32'(converter_halted), 32'h1);
		chk(32'(irq), 32'h1);
		rd(OFS_FLOW, 32'h0);
		rd(OFS_STAT, 32'h4);
		wr(OFS_CTRL, 32'h0);
		// The halt clears one edge after the enable bit drops.
		@(posedge mclk);
		chk(32'(converter_halted), 32'h0);
		$display("test trigger mode done");
		stop_test();
	end
endmodule
`default_nettype wire
